// ===== rtl/stot_params.svh
`ifndef STOT_PARAMS_SVH
`define STOT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (printed offsets, not all multiples of four)
// ----------------------------------------------------------------------------
`define STOT_IDX_SPARE_SECOND_TIMING 12'h088
`define STOT_IDX_SECOND_DUAL_TIMING  12'h089
`define STOT_IDX_FIRST_INA_OFFSET    12'h08A
`define STOT_IDX_FIRST_INB_OFFSET    12'h08C
`define STOT_IDX_SPARE_INA_OFFSET    12'h08E
`define STOT_IDX_CAL_CONTROL         12'h0A0
`define STOT_IDX_CAL_STATUS          12'h0A1

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define STOT_TIMING_W        8
`define STOT_OFFSET_W        12
`define STOT_OFFSET_REG_W    16
`define STOT_RSVD_LSB        12
`define STOT_CTRL_BG_BIT     0
`define STOT_CTRL_BGOS_BIT   1
`define STOT_CTRL_OS_BIT     2
`define STOT_STAT_FGRUN_BIT  0
`define STOT_STAT_FGDONE_BIT 1
`define STOT_STAT_HALT_BIT   2
`define STOT_STAT_WDROP_BIT  3
`define STOT_STAT_RBLOCK_BIT 4

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define STOT_CTRL_RESET  3'h0
`define STOT_TRIM_COUNT  5
`define STOT_SYNC_STAGES 3

`endif

// ===== rtl/stot_pkg.sv
package stot_pkg;

  // Trim values presented to the converter cores
  typedef struct packed {
    logic [7:0]  spare_for_second_timing;
    logic [7:0]  second_dual_timing;
    logic [11:0] first_ina_offset;
    logic [11:0] first_inb_offset;
    logic [11:0] spare_ina_offset;
  } stot_trim_type;

  // Calibration status seen from the engines
  typedef struct packed {
    logic fg_running;
    logic foreground_cal_done_flag;
    logic halted;
  } stot_cal_status_type;

  typedef enum logic [1:0] {
    STOT_IDLE   = 2'b00,
    STOT_ACCESS = 2'b01
  } stot_bus_state_type;

endpackage

// ===== rtl/stot_trim_store.sv
`timescale 1ns/100ps
`include "stot_params.svh"

// Trim word store: reloads the factory word just after reset, retains writes.
module stot_trim_store #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             load_req,
  input  wire logic [WIDTH-1:0] factory_val,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] value_q
);

  initial begin
    if (WIDTH < 1 || WIDTH > 16) $error("stot_trim_store: bad WIDTH");
  end

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  // Async reset may only load a constant, so the factory word is
  // captured by the clocked reload pulse just after release.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      value_q <= '0;
    end else if (load_req) begin
      value_q <= factory_val;
    end else if (wr_en) begin
      value_q <= wr_data;
    end
  end

endmodule

// ===== rtl/stot_sync3.sv
`timescale 1ns/100ps

// Three-stage synchroniser; a change counts once stages two and three agree.
module stot_sync3 #(
  parameter int WIDTH = 3
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  initial begin
    if (WIDTH < 1) $error("stot_sync3: bad WIDTH");
  end

  // ---------------------------------------------------------------------
  // Shift chain with agreement filter
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      sync_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// ===== rtl/stot_trim_regs.sv
// How it works
// - Each 8-bit timing trim shifts one core's sampling instant.
// - Timing trims load factory value after reset, readable and writable.
// - Spare-for-second timing at 0x088, second-core dual timing at 0x089.
// - First core input A offset: 12-bit unsigned, index 0x08A.
// - First core input B offset: 12-bit unsigned, index 0x08C.
// - Offsets unsigned; factory value loaded after reset, readable, adjustable.
// - Spare core input A offset at 0x08E; bits 15-12 reserved.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "stot_params.svh"

module stot_trim_regs
  import stot_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire stot_trim_type factory_trim,
  input  wire logic          fg_running,
  input  wire logic          foreground_cal_done_flag,
  input  wire logic          cal_halted,
  output stot_trim_type      trim_q,
  output logic               background_cal_enable,
  output logic               background_offset_cal_enable,
  output logic               offset_cal_enable
);

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] idx);
    hit = (addr[11:2] == idx[9:0]) && (addr[1:0] == 2'b00);
  endfunction

  stot_bus_state_type state_q;
  stot_bus_state_type state_d;
  logic               load_q;
  logic [2:0]         ctrl_q;
  logic               wdrop_q;
  logic [2:0]         cal_sync;
  stot_cal_status_type cal_st;

  // Setup is seen in idle, the answer is launched after the wait state,
  // and a write commits only where the master samples pready high, so a
  // request abandoned early never touches a trim.
  wire setup       = psel && !penable;
  wire acc_take    = psel && penable && (state_q == STOT_ACCESS);
  wire commit      = psel && penable && pready;
  wire wr_take     = commit && pwrite && pstrb[0];
  wire hit_tsec    = hit(paddr, `STOT_IDX_SPARE_SECOND_TIMING);
  wire hit_tdual   = hit(paddr, `STOT_IDX_SECOND_DUAL_TIMING);
  wire hit_oina    = hit(paddr, `STOT_IDX_FIRST_INA_OFFSET);
  wire hit_oinb    = hit(paddr, `STOT_IDX_FIRST_INB_OFFSET);
  wire hit_ospare  = hit(paddr, `STOT_IDX_SPARE_INA_OFFSET);
  wire hit_ctrl    = hit(paddr, `STOT_IDX_CAL_CONTROL);
  wire hit_stat    = hit(paddr, `STOT_IDX_CAL_STATUS);
  wire hit_offset  = hit_oina || hit_oinb || hit_ospare;
  wire mapped      = hit_tsec || hit_tdual || hit_offset || hit_ctrl || hit_stat;

  // Offset writes are ignored while calibration owns the trims.
  wire wr_locked   = cal_st.fg_running ||
                     (ctrl_q[`STOT_CTRL_BG_BIT] && ctrl_q[`STOT_CTRL_BGOS_BIT]);
  // Read window: reads outside it still answer; status bit 4 shows the live blocked state.
  wire rd_fg_mode  = ctrl_q[`STOT_CTRL_OS_BIT] && !ctrl_q[`STOT_CTRL_BGOS_BIT];
  wire rd_bg_mode  = ctrl_q[`STOT_CTRL_BG_BIT] && ctrl_q[`STOT_CTRL_BGOS_BIT];
  wire rd_blocked  = (rd_fg_mode && !cal_st.foreground_cal_done_flag) ||
                     (rd_bg_mode && !cal_st.halted);
  wire off_wr_ok   = wr_take && hit_offset && pstrb[1] && !wr_locked;

  // Per-word write enables; timing words are never locked by calibration
  wire wr_tsec     = wr_take && hit_tsec;
  wire wr_tdual    = wr_take && hit_tdual;
  wire wr_oina     = off_wr_ok && hit_oina;
  wire wr_oinb     = off_wr_ok && hit_oinb;
  wire wr_ospare   = off_wr_ok && hit_ospare;

  assign cal_st = '{fg_running: cal_sync[2], foreground_cal_done_flag: cal_sync[1], halted: cal_sync[0]};

  // ---------------------------------------------------------------------
  // Layout sanity
  // ---------------------------------------------------------------------
  // The read mux pads with fixed widths; other field sizes would misplace
  // data on the bus, so they raise an error when simulation starts.
  initial begin
    if (`STOT_TIMING_W != 8) $error("stot_trim_regs: timing width must be 8");
    if (`STOT_OFFSET_W != 12) $error("stot_trim_regs: offset width must be 12");
    if (`STOT_RSVD_LSB != `STOT_OFFSET_W) $error("stot_trim_regs: reserved field misplaced");
    if (`STOT_OFFSET_REG_W != 16) $error("stot_trim_regs: offset word must be 16 bits");
    if (`STOT_TRIM_COUNT != 5) $error("stot_trim_regs: five trim words expected");
    if (`STOT_SYNC_STAGES != 3) $error("stot_trim_regs: three sync stages expected");
  end

  // ---------------------------------------------------------------------
  // Calibration status synchroniser
  // ---------------------------------------------------------------------
  stot_sync3 #(
    .WIDTH (3)
  ) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({fg_running, foreground_cal_done_flag, cal_halted}),
    .sync_q   (cal_sync)
  );

  // ---------------------------------------------------------------------
  // Trim storage
  // ---------------------------------------------------------------------
  // Spare core standing in for the second core, dual-channel mode
  stot_trim_store #(.WIDTH(`STOT_TIMING_W)) u_tsec (
    .mclk        (mclk),
    .rst         (rst),
    .load_req    (load_q),
    .factory_val (factory_trim.spare_for_second_timing),
    .wr_en       (wr_tsec),
    .wr_data     (pwdata[7:0]),
    .value_q     (trim_q.spare_for_second_timing)
  );

  // Second core itself, dual-channel mode
  stot_trim_store #(.WIDTH(`STOT_TIMING_W)) u_tdual (
    .mclk        (mclk),
    .rst         (rst),
    .load_req    (load_q),
    .factory_val (factory_trim.second_dual_timing),
    .wr_en       (wr_tdual),
    .wr_data     (pwdata[7:0]),
    .value_q     (trim_q.second_dual_timing)
  );

  // First core sampling input A
  stot_trim_store #(.WIDTH(`STOT_OFFSET_W)) u_oina (
    .mclk        (mclk),
    .rst         (rst),
    .load_req    (load_q),
    .factory_val (factory_trim.first_ina_offset),
    .wr_en       (wr_oina),
    .wr_data     (pwdata[11:0]),
    .value_q     (trim_q.first_ina_offset)
  );

  // First core sampling input B
  stot_trim_store #(.WIDTH(`STOT_OFFSET_W)) u_oinb (
    .mclk        (mclk),
    .rst         (rst),
    .load_req    (load_q),
    .factory_val (factory_trim.first_inb_offset),
    .wr_en       (wr_oinb),
    .wr_data     (pwdata[11:0]),
    .value_q     (trim_q.first_inb_offset)
  );

  // Spare core sampling input A
  stot_trim_store #(.WIDTH(`STOT_OFFSET_W)) u_ospare (
    .mclk        (mclk),
    .rst         (rst),
    .load_req    (load_q),
    .factory_val (factory_trim.spare_ina_offset),
    .wr_en       (wr_ospare),
    .wr_data     (pwdata[11:0]),
    .value_q     (trim_q.spare_ina_offset)
  );

  // ---------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------
  // Reserved bits 15-12 of offset words always read zero.
  wire [31:0] rd_timing =
    hit_tsec   ? {24'h000000, trim_q.spare_for_second_timing} :
    hit_tdual  ? {24'h000000, trim_q.second_dual_timing} :
                 32'h00000000;
  wire [31:0] rd_offset =
    hit_oina   ? {20'h00000, trim_q.first_ina_offset} :
    hit_oinb   ? {20'h00000, trim_q.first_inb_offset} :
    hit_ospare ? {20'h00000, trim_q.spare_ina_offset} :
                 32'h00000000;

  // Status word: live engine levels, sticky drop flag, live window flag
  wire [31:0] rd_misc =
    hit_ctrl   ? {29'h00000000, ctrl_q} :
    hit_stat   ? {27'h0000000, rd_blocked, wdrop_q, cal_st.halted,
                  cal_st.foreground_cal_done_flag, cal_st.fg_running} :
                 32'h00000000;

  // Decodes are one-hot, so the groups merge with a plain or
  wire [31:0] rd_mux = rd_timing | rd_offset | rd_misc;

  // ---------------------------------------------------------------------
  // APB phase tracking: one wait state, answer in the second access cycle
  // ---------------------------------------------------------------------
  // A master that drops psel mid-transfer returns the tracker to idle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      STOT_IDLE: begin
        if (setup) state_d = STOT_ACCESS;
      end
      STOT_ACCESS: begin
        if (acc_take) state_d = STOT_IDLE;
        else if (!psel) state_d = STOT_IDLE;
      end
      default: state_d = STOT_IDLE;
    endcase
  end

  // Phase register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= STOT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------
  // Reply flops
  // ---------------------------------------------------------------------
  // Ready pulses once: the tracker has left the access state by the edge
  // at which the master samples it, so it cannot repeat.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= acc_take;
    end
  end

  // Read data load with ready so both stand for the same cycle;
  // forbidden-window reads still return data and only raise a flag.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= (acc_take && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Holes in the map answer with an error; writes there are discarded.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= acc_take && !mapped;
    end
  end

  // ---------------------------------------------------------------------
  // Factory reload pulse
  // ---------------------------------------------------------------------
  // Async reset may only load constants, so the stores take the factory
  // words on the first clock after release instead.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Calibration control and dropped-write flag
  // ---------------------------------------------------------------------
  // Control and flag change only on the commit edge, like the trims.
  wire ctrl_wr   = wr_take && hit_ctrl;
  wire wdrop_set = wr_take && hit_offset && wr_locked;
  wire wdrop_clr = wr_take && hit_stat && pwdata[`STOT_STAT_WDROP_BIT];

  // Control bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `STOT_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // Dropped-write flag: set wins over a clear in the same cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wdrop_q <= 1'b0;
    end else if (wdrop_set) begin
      wdrop_q <= 1'b1;
    end else if (wdrop_clr) begin
      wdrop_q <= 1'b0;
    end
  end

  // Enables leave straight from the control flops
  assign background_cal_enable        = ctrl_q[`STOT_CTRL_BG_BIT];
  assign background_offset_cal_enable = ctrl_q[`STOT_CTRL_BGOS_BIT];
  assign offset_cal_enable            = ctrl_q[`STOT_CTRL_OS_BIT];

endmodule

// ===== verification/stot_trim_regs_checker.sv
`timescale 1ns/100ps
module stot_trim_regs_checker
  import stot_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic [31:0]   prdata,
  input wire stot_trim_type trim_q,
  input wire logic          background_cal_enable,
  input wire logic          background_offset_cal_enable
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Read strobe and field taps, so $past sees plain signals
  wire       rd  = pready && !pwrite;
  wire       tk  = psel && penable && pready && pwrite;
  wire [7:0] wlo = pwdata[7:0];
  wire [11:0] ofa = trim_q.first_ina_offset;
  wire       bgo = background_cal_enable && background_offset_cal_enable;
  sequence wr_dual_s;
    tk && paddr == 12'h224;
  endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  read_spare_a: assert property (
    rd && paddr == 12'h220 |-> prdata == {24'h0, trim_q.spare_for_second_timing})
    else $error("spare timing readback wrong");
  read_dual_a: assert property (
    rd && paddr == 12'h224 |-> prdata == {24'h0, trim_q.second_dual_timing})
    else $error("dual timing readback wrong");
  read_ofa_a: assert property (
    rd && paddr == 12'h228 |-> prdata == {20'h0, ofa})
    else $error("first A offset readback wrong");
  read_ofb_a: assert property (
    rd && paddr == 12'h230 |-> prdata == {20'h0, trim_q.first_inb_offset})
    else $error("first B offset readback wrong");
  rsvd_zero_a: assert property (
    rd && paddr == 12'h238 |-> prdata == {20'h0, trim_q.spare_ina_offset})
    else $error("spare offset or reserved bits wrong");
  hold_trim_a: assert property (
    !(psel && pwrite) && !$past(rst) |=> $stable(trim_q))
    else $error("trim changed without a write");
  write_dual_a: assert property (
    wr_dual_s |=> trim_q.second_dual_timing == $past(wlo))
    else $error("dual timing write lost");
  refuse_bgos_a: assert property (
    tk && paddr == 12'h228 && bgo |=> $stable(ofa))
    else $error("offset written during background cal");
endmodule

bind stot_trim_regs stot_trim_regs_checker stot_trim_regs_checker_inst (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .trim_q(trim_q),
  .background_cal_enable(background_cal_enable),
  .background_offset_cal_enable(background_offset_cal_enable));

// ===== verification/stot_trim_regs_tb_top.sv
`timescale 1ns/100ps
module stot_trim_regs_tb_top;
  import stot_pkg::*;
  // ---------------------------------------------------------------
  // Signals and model
  // ---------------------------------------------------------------
  logic          mclk, rst, psel, penable, pwrite, pready, pslverr, ev;
  logic          fg_running, foreground_cal_done_flag, cal_halted, bg_en, bgos_en, os_en;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, seed, rv;
  stot_trim_type factory_trim, trim_q;
  int            fail_count, cmp_count;
  int            mdl [5];
  logic [11:0]   adr [5] = '{12'h220, 12'h224, 12'h228, 12'h230, 12'h238};
  int            msk [5] = '{32'hFF, 32'hFF, 32'hFFF, 32'hFFF, 32'hFFF};

  stot_trim_regs stot_trim_regs_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .factory_trim(factory_trim),
    .fg_running(fg_running), .foreground_cal_done_flag(foreground_cal_done_flag), .cal_halted(cal_halted),
    .trim_q(trim_q), .background_cal_enable(bg_en),
    .background_offset_cal_enable(bgos_en), .offset_cal_enable(os_en));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Model image of what the cores should see
  function automatic stot_trim_type exp_trim();
    return {mdl[0][7:0], mdl[1][7:0], mdl[2][11:0], mdl[3][11:0], mdl[4][11:0]};
  endfunction
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", n, 2);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // New factory words, then a 12-cycle reset
  task automatic do_reset();
    for (int i = 0; i < 5; i++) begin
      mdl[i] = xs() & msk[i];
    end
    factory_trim <= exp_trim();
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic check_all();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, adr[i], 32'h0);
      chk("trim read", rv, mdl[i] & msk[i]);
      chk("trim slverr", ev, 1'b0);
    end
    chk("trim out", trim_q, exp_trim());
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h55;
    fail_count = 0;
    cmp_count = 0;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {fg_running, foreground_cal_done_flag, cal_halted, factory_trim} = '0;
    do_reset();
    check_all();
    // Raw random words: reserved offset bits must read back zero
    for (int k = 0; k < 10; k++) begin
      mdl[k % 5] = xs();
      apb(1'b1, adr[k % 5], mdl[k % 5]);
    end
    repeat (8) @(posedge mclk);
    check_all();
    apb(1'b0, 12'h300, 32'h0);
    chk("unmapped", {ev, rv}, {1'b1, 32'h0});
    // Background offset mode: offset write must be dropped
    apb(1'b1, 12'h280, 32'h3);
    // Control flops load on the commit edge; look one edge later
    @(posedge mclk);
    chk("cal enables", {os_en, bgos_en, bg_en}, 3'h3);
    apb(1'b1, 12'h228, xs());
    cal_halted <= 1'b1;
    repeat (6) @(posedge mclk);
    check_all();
    apb(1'b0, 12'h284, 32'h0);
    chk("drop flag", rv[3], 1'b1);
    apb(1'b1, 12'h284, 32'h8);
    apb(1'b0, 12'h284, 32'h0);
    chk("drop clear", rv[3], 1'b0);
    apb(1'b1, 12'h280, 32'h0);
    cal_halted <= 1'b0;
    // Foreground run: offsets refused, timing still taken
    fg_running <= 1'b1;
    repeat (6) @(posedge mclk);
    apb(1'b1, 12'h230, xs());
    mdl[0] = xs();
    apb(1'b1, 12'h220, mdl[0]);
    fg_running <= 1'b0;
    foreground_cal_done_flag <= 1'b1;
    apb(1'b1, 12'h280, 32'h4);
    repeat (6) @(posedge mclk);
    chk("os enable", {os_en, bgos_en, bg_en}, 3'h4);
    check_all();
    // Done withdrawn: the status word must show the closed read window
    foreground_cal_done_flag <= 1'b0;
    repeat (6) @(posedge mclk);
    apb(1'b0, 12'h284, 32'h0);
    chk("window flag", rv[4], 1'b1);
    do_reset();
    check_all();
    wrap_up();
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
endmodule
